//--- bench/lbsp_remote_node.sv
// remote bus node model: frame receiver and frame sender on the serial line
`timescale 1ns/10ps
module lbsp_remote_node #(
    parameter int BIT_CLKS = 4
) (
    // clock
    input  wire logic i_clk,
    // serial line
    input  wire logic i_line,
    output logic      o_line
);
    // ------------------------------------------------------------
    // frame capture
    // ------------------------------------------------------------
    logic [7:0] got_byte[$];
    int         got_zeros[$];
    logic [7:0] sh;
    int         nz;

    // recessive level while idle, as a pulled-up bus would show
    initial o_line = 1'b1;

    // low-bit count: a break shows as 13
    always begin
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            sh[i] = i_line;
        end
        nz = (sh == 8'h00) ? 9 : 1;
        repeat (BIT_CLKS) @(posedge i_clk);
        // limit keeps a stuck-low line from hanging the model
        while (i_line === 1'b0 && nz < 40) begin
            nz++;
            repeat (BIT_CLKS) @(posedge i_clk);
        end
        got_zeros.push_back(nz);
        got_byte.push_back(sh);
    end

    // break sent at the agreed bit time
    task automatic send_brk;
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (13 * BIT_CLKS) @(posedge i_clk);
        o_line <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge i_clk);
    endtask

    task automatic send_byte(input logic [7:0] b);
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (BIT_CLKS) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            o_line <= b[i];
            repeat (BIT_CLKS) @(posedge i_clk);
        end
        o_line <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge i_clk);
    endtask
endmodule // lbsp_remote_node

//--- bench/test_lin_break_serial_port.sv
// self-checking bench for the break-capable serial port
`timescale 1ns/10ps
module test_lin_break_serial_port;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    localparam int BITC = 4;
    logic       clk       = 1'b0;
    logic       rstn      = 1'b0;
    logic [3:0] addr      = 4'h0;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic [7:0] rdata;
    logic       dt_o;
    logic       dt_oe;
    logic       ck_o;
    logic       ck_oe;
    logic       irq;
    logic       node_tx;
    logic [7:0] v;
    logic       c0;
    int         seen;
    int         n_errors  = 0;
    int         tests_run = 0;
    // undriven data pin takes the remote node's line; undriven clock pin falls back to the bus idle level
    wire        dt_w      = dt_oe ? dt_o : node_tx;
    wire        ck_w      = ck_oe ? ck_o : 1'b1;

    always #5 clk = ~clk;

    lbsp_top uut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RECEIVE_DATA_PIN(dt_w), .O_RECEIVE_DATA_PIN(dt_o),
        .O_RECEIVE_DATA_PIN_OE(dt_oe), .I_TX_CK(ck_w), .O_TX_CK(ck_o), .O_TX_CK_OE(ck_oe),
        .O_IRQ(irq));
    lbsp_remote_node #(.BIT_CLKS(BITC)) node (.i_clk(clk), .i_line(ck_w), .o_line(node_tx));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_stat(input int b);
        v = 8'h00;
        for (int n = 0; n < 200 && v[b] !== 1'b1; n++) rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
    endtask

    task automatic wait_frames(input int n);
        for (int i = 0; i < 600 && node.got_byte.size() < n; i++) @(posedge clk);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_reg(lbsp_pkg::REG_TX_CTRL, v);
        chk(v, lbsp_pkg::TXC_RESET);
        rd_reg(lbsp_pkg::REG_BAUD_DIV, v);
        chk(v, lbsp_pkg::DIV_RESET[7:0]);
        rd_reg(4'h9, v);
        chk(v, 8'h00);
        chk(irq, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_byte;
        // port enabled by software before use
        wr_reg(lbsp_pkg::REG_BAUD_DIV, 8'h03);
        wr_reg(lbsp_pkg::REG_RX_CTRL, 8'h90);
        wr_reg(lbsp_pkg::REG_TX_CTRL, 8'h20);
        wr_reg(lbsp_pkg::REG_IRQ_CLR, 8'h07);
        wr_reg(lbsp_pkg::REG_TX_HOLD, 8'ha5);
        rd_reg(lbsp_pkg::REG_TX_CTRL, v);
        chk(v[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG], 1'b0);
        wait_frames(1);
        chk(node.got_byte.size(), 16'd1);
        chk(node.got_zeros.pop_front(), 16'd1);
        chk(node.got_byte.pop_front(), 8'ha5);
        repeat (2 * BITC) @(posedge clk);
        rd_reg(lbsp_pkg::REG_TX_CTRL, v);
        chk(v[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG], 1'b1);
        rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
        chk(v[lbsp_pkg::EV_TXBE], 1'b1);
        $display("test byte done");
    endtask

    task automatic t_break;
        wr_reg(lbsp_pkg::REG_IRQ_CLR, 8'h07);
        // header: send-break, dummy byte, then sync value
        wr_reg(lbsp_pkg::REG_TX_CTRL, 8'h28);
        wr_reg(lbsp_pkg::REG_TX_HOLD, 8'hff);
        wait_stat(lbsp_pkg::EV_TXBE);
        chk(v[lbsp_pkg::EV_TXBE], 1'b1);
        wr_reg(lbsp_pkg::REG_TX_HOLD, 8'h55);
        rd_reg(lbsp_pkg::REG_TX_CTRL, v);
        chk(v[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG], 1'b0);
        chk(v[lbsp_pkg::TXC_SEND_BREAK_REQUEST], 1'b1);
        wait_frames(2);
        chk(node.got_byte.size(), 16'd2);
        chk(node.got_zeros.pop_front(), 16'd13);
        chk(node.got_byte.pop_front(), 8'h00);
        chk(node.got_zeros.pop_front(), 16'd1);
        chk(node.got_byte.pop_front(), 8'h55);
        repeat (2 * BITC) @(posedge clk);
        rd_reg(lbsp_pkg::REG_TX_CTRL, v);
        chk(v[lbsp_pkg::TXC_SEND_BREAK_REQUEST], 1'b0);
        chk(v[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG], 1'b1);
        rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
        chk(v, 8'h05);
        // auto-baud bit once the buffer flag was seen
        wr_reg(lbsp_pkg::REG_BAUD_CTL, 8'h01);
        rd_reg(lbsp_pkg::REG_BAUD_CTL, v);
        chk(v, 8'h01);
        $display("test break done");
    endtask

    task automatic t_irq;
        wr_reg(lbsp_pkg::REG_IRQ_EN, 8'h00);
        settle();
        chk(irq, 1'b0);
        wr_reg(lbsp_pkg::REG_IRQ_EN, 8'h04);
        settle();
        chk(irq, 1'b1);
        wr_reg(lbsp_pkg::REG_IRQ_STAT, 8'h00);
        rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
        chk(v, 8'h05);
        wr_reg(lbsp_pkg::REG_IRQ_CLR, 8'h04);
        settle();
        chk(irq, 1'b0);
        rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
        chk(v, 8'h01);
        $display("test irq done");
    endtask

    task automatic t_wake;
        wr_reg(lbsp_pkg::REG_IRQ_CLR, 8'h07);
        wr_reg(lbsp_pkg::REG_IRQ_EN, 8'h02);
        wr_reg(lbsp_pkg::REG_BAUD_CTL, 8'h02);
        node.send_brk();
        rd_reg(lbsp_pkg::REG_IRQ_STAT, v);
        chk(v[lbsp_pkg::EV_RXRDY], 1'b1);
        chk(irq, 1'b1);
        rd_reg(lbsp_pkg::REG_BAUD_CTL, v);
        chk(v[lbsp_pkg::BDC_WAKE], 1'b0);
        wr_reg(lbsp_pkg::REG_IRQ_CLR, 8'h02);
        node.send_byte(8'h3c);
        wait_stat(lbsp_pkg::EV_RXRDY);
        chk(v[lbsp_pkg::EV_RXRDY], 1'b1);
        rd_reg(lbsp_pkg::REG_RX_DATA, v);
        chk(v, 8'h3c);
        $display("test wake done");
    endtask

    task automatic t_sync;
        wr_reg(lbsp_pkg::REG_BAUD_CTL, 8'h00);
        wr_reg(lbsp_pkg::REG_TX_CTRL, 8'hb0);
        settle();
        c0 = ck_o;
        wr_reg(lbsp_pkg::REG_TX_HOLD, 8'h81);
        seen = 0;
        repeat (200) begin
            @(posedge clk);
            #1;
            if (dt_oe === 1'b1) seen++;
        end
        chk(seen != 0, 1'b1);
        wr_reg(lbsp_pkg::REG_BAUD_CTL, 8'h10);
        settle();
        chk(ck_o, !c0);
        $display("test sync done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_byte();
        t_break();
        t_irq();
        t_wake();
        t_sync();
        report_and_stop();
    end

    // whole run needs well under a thousand cycles; this bounds a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule // test_lin_break_serial_port

//--- hdl/lbsp_pkg.sv
// package: register map, fields and timing for the break-capable serial port
package lbsp_pkg;
    // register offsets (word index on the plain register port)
    localparam logic [3:0] REG_TX_CTRL  = 4'h0; // transmit control/status
    localparam logic [3:0] REG_RX_CTRL  = 4'h1; // receive control/status
    localparam logic [3:0] REG_BAUD_CTL = 4'h2; // baud control
    localparam logic [3:0] REG_BAUD_DIV = 4'h3; // bit period divider
    localparam logic [3:0] REG_TX_HOLD  = 4'h4; // transmit holding register
    localparam logic [3:0] REG_RX_DATA  = 4'h5; // received byte
    localparam logic [3:0] REG_IRQ_STAT = 4'h6; // sticky events, read only
    localparam logic [3:0] REG_IRQ_CLR  = 4'h7; // write one to clear
    localparam logic [3:0] REG_IRQ_EN   = 4'h8; // interrupt enable
    // transmit control/status fields
    localparam int TXC_SYNC   = 4;
    localparam int TXC_MASTER = 7;
    localparam int TXC_TRANSMIT_ENABLE_BIT   = 5;
    localparam int TXC_SEND_BREAK_REQUEST  = 3;
    localparam int TXC_SHIFT_REGISTER_EMPTY_FLAG   = 1;
    // receive control/status fields
    localparam int RXC_SERIAL_PORT_ENABLE   = 7;
    localparam int RXC_CREN   = 4;
    // baud control fields
    localparam int BDC_CKPOL  = 4;
    localparam int BDC_WAKE   = 1;
    localparam int BDC_ABD    = 0;
    // event bits
    localparam int EV_TXBE    = 0;
    localparam int EV_RXRDY   = 1;
    localparam int EV_BRKDONE = 2;
    localparam int EV_WIDTH   = 3;
    // reset values
    localparam logic [7:0]  TXC_RESET  = 8'h02;
    localparam logic [15:0] DIV_RESET  = 16'h0363;
    // frame sizes
    localparam logic [3:0] DATA_BITS  = 4'h8;
    localparam logic [3:0] BREAK_BITS = 4'hc;
    localparam logic [1:0] WAKE_EDGES = 2'h2;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } lbsp_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_WAKE  = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } lbsp_rx_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } lbsp_bus_s;
endpackage

//--- hdl/lbsp_top.sv
// break-capable serial port: transmit, receive, auto-wake, registers, interrupt
//
// Functional notes
// RL1: software enables the port and sets both pin directions before use.
// RL2: asynchronous full duplex, synchronous master and slave with clock polarity.
// RL3: break is start bit, twelve zero bits, one stop bit.
// RL4: break sent when send-break and transmit enable set at shift load.
// RL5: break trigger byte is discarded; zeros are shifted out.
// RL6: send-break request clears itself after the break stop bit.
// RL7: next byte may be preloaded during break and follows afterward.
// RL8: shift-register-empty flag behaves alike for break and characters.
// RL9: header is dummy byte with break set, then sync value 55h.
// RL10: buffer-empty flag rises when holding register empties; software waits.
// RL11: first break receive method uses 9/13 baud set by software.
// RL12: auto-wake counts two receive edges, interrupts, then receives next byte.
// RL13: software may enable auto-baud after break, once transmit flag seen.
`timescale 1ns/10ps
module lbsp_top (
    // clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RESETN,
    // register port
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // serial pins
    input  wire logic       I_RECEIVE_DATA_PIN,
    output logic            O_RECEIVE_DATA_PIN,
    output logic            O_RECEIVE_DATA_PIN_OE,
    input  wire logic       I_TX_CK,
    output logic            O_TX_CK,
    output logic            O_TX_CK_OE,
    // interrupt
    output logic            O_IRQ
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    lbsp_pkg::lbsp_bus_s bus;
    assign bus = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

    function automatic logic hit(input lbsp_pkg::lbsp_bus_s b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    logic [7:0]  txc_q, rxc_q, bdc_q, hold_q, rxd_q;
    logic [15:0] div_q;
    logic        hold_full_q;
    logic [lbsp_pkg::EV_WIDTH-1:0] stat_q, en_q, ev;
    logic        send_break_request_clr, hold_take, rx_done;
    lbsp_pkg::lbsp_tx_e tx_q;
    lbsp_pkg::lbsp_rx_e rx_q;

    logic en_port, sync_m, sync_s;
    assign en_port = rxc_q[lbsp_pkg::RXC_SERIAL_PORT_ENABLE];
    assign sync_m  = txc_q[lbsp_pkg::TXC_SYNC] && txc_q[lbsp_pkg::TXC_MASTER];
    assign sync_s  = txc_q[lbsp_pkg::TXC_SYNC] && !txc_q[lbsp_pkg::TXC_MASTER];

    // RL6: self-clearing request
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            txc_q <= lbsp_pkg::TXC_RESET;
        end else begin
            if (hit(bus, lbsp_pkg::REG_TX_CTRL)) begin
                txc_q <= bus.wdata;
            end
            if (send_break_request_clr) begin
                txc_q[lbsp_pkg::TXC_SEND_BREAK_REQUEST] <= 1'b0;
            end
            // RL8: empty flag tracks shifter
            // drop on the load edge so a read right after the load sees it busy
            txc_q[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG] <= (tx_q == lbsp_pkg::TX_IDLE) && !hold_take;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            rxc_q <= 8'h00;
            bdc_q <= 8'h00;
            div_q <= lbsp_pkg::DIV_RESET;
            en_q  <= '0;
        end else begin
            if (hit(bus, lbsp_pkg::REG_RX_CTRL)) rxc_q <= bus.wdata;
            if (hit(bus, lbsp_pkg::REG_BAUD_CTL)) bdc_q <= bus.wdata;
            if (hit(bus, lbsp_pkg::REG_BAUD_DIV)) div_q <= {8'h00, bus.wdata};
            if (hit(bus, lbsp_pkg::REG_IRQ_EN)) en_q <= bus.wdata[lbsp_pkg::EV_WIDTH-1:0];
            // RL12: wake bit drops once wake edges are seen
            if (rx_q == lbsp_pkg::RX_WAKE && ev[lbsp_pkg::EV_RXRDY]) begin
                bdc_q[lbsp_pkg::BDC_WAKE] <= 1'b0;
            end
        end
    end

    // RL7: holding register accepts a byte while break shifts
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
        end else if (hit(bus, lbsp_pkg::REG_TX_HOLD)) begin
            hold_q      <= bus.wdata;
            hold_full_q <= 1'b1;
        end else if (hold_take) begin
            hold_full_q <= 1'b0;
        end
    end

    // sticky events; set wins over clear
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(hit(bus, lbsp_pkg::REG_IRQ_CLR) ?
                       bus.wdata[lbsp_pkg::EV_WIDTH-1:0] : '0)) | ev;
        end
    end
    assign O_IRQ = |(stat_q & en_q);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            O_RDATA <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                lbsp_pkg::REG_TX_CTRL:  O_RDATA <= txc_q;
                lbsp_pkg::REG_RX_CTRL:  O_RDATA <= rxc_q;
                lbsp_pkg::REG_BAUD_CTL: O_RDATA <= bdc_q;
                lbsp_pkg::REG_BAUD_DIV: O_RDATA <= div_q[7:0];
                lbsp_pkg::REG_RX_DATA:  O_RDATA <= rxd_q;
                lbsp_pkg::REG_IRQ_STAT: O_RDATA <= {5'h00, stat_q};
                lbsp_pkg::REG_IRQ_EN:   O_RDATA <= {5'h00, en_q};
                default:                O_RDATA <= 8'h00;
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers and bit timing
    // ------------------------------------------------------------
    logic rx_m_q, rx_s_q, rx_d_q, ck_m_q, ck_s_q, ck_d_q;
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            {rx_m_q, rx_s_q, rx_d_q} <= 3'b111;
            {ck_m_q, ck_s_q, ck_d_q} <= 3'b000;
        end else begin
            rx_m_q <= I_RECEIVE_DATA_PIN;
            rx_s_q <= rx_m_q;
            rx_d_q <= rx_s_q;
            ck_m_q <= I_TX_CK;
            ck_s_q <= ck_m_q;
            ck_d_q <= ck_s_q;
        end
    end

    // RL2: polarity and slave clock edge
    logic ckp, slv_edge, rx_edge;
    assign ckp      = bdc_q[lbsp_pkg::BDC_CKPOL];
    assign slv_edge = (ck_s_q ^ ckp) && !(ck_d_q ^ ckp);
    assign rx_edge  = rx_s_q ^ rx_d_q;

    logic [15:0] tcnt_q;
    logic        tick, mck_q;
    assign tick = (tcnt_q == div_q);
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN || tx_q == lbsp_pkg::TX_IDLE) begin
            tcnt_q <= 16'h0000;
        end else begin
            tcnt_q <= tick ? 16'h0000 : tcnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic       brk_q, tx_q_pin, step;
    assign step = sync_s ? slv_edge : tick;
    assign hold_take = (tx_q == lbsp_pkg::TX_IDLE) && hold_full_q &&
                       txc_q[lbsp_pkg::TXC_TRANSMIT_ENABLE_BIT] && en_port;
    assign send_break_request_clr = (tx_q == lbsp_pkg::TX_STOP) && step && brk_q;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            tx_q     <= lbsp_pkg::TX_IDLE;
            sh_q     <= 8'h00;
            bit_q    <= 4'h0;
            brk_q    <= 1'b0;
            tx_q_pin <= 1'b1;
            mck_q    <= 1'b0;
        end else begin
            case (tx_q)
                lbsp_pkg::TX_IDLE: begin
                    tx_q_pin <= 1'b1;
                    mck_q    <= 1'b0;
                    if (hold_take) begin
                        // RL4: break latched at shift load
                        brk_q <= txc_q[lbsp_pkg::TXC_SEND_BREAK_REQUEST] && !txc_q[lbsp_pkg::TXC_SYNC];
                        // RL5: break byte discarded
                        sh_q  <= txc_q[lbsp_pkg::TXC_SEND_BREAK_REQUEST] ? 8'h00 : hold_q;
                        bit_q <= 4'h0;
                        tx_q  <= txc_q[lbsp_pkg::TXC_SYNC] ? lbsp_pkg::TX_DATA
                                                           : lbsp_pkg::TX_START;
                        tx_q_pin <= txc_q[lbsp_pkg::TXC_SYNC] ? hold_q[0] : 1'b0;
                    end
                end
                lbsp_pkg::TX_START: begin
                    if (step) begin
                        tx_q     <= lbsp_pkg::TX_DATA;
                        tx_q_pin <= sh_q[0];
                    end
                end
                lbsp_pkg::TX_DATA: begin
                    if (tick && sync_m) mck_q <= ~mck_q;
                    if (step && (!sync_m || mck_q)) begin
                        // RL3: twelve zero bits for break
                        if (bit_q == (brk_q ? lbsp_pkg::BREAK_BITS : lbsp_pkg::DATA_BITS)
                                     - 4'h1) begin
                            tx_q     <= lbsp_pkg::TX_STOP;
                            tx_q_pin <= 1'b1;
                        end else begin
                            tx_q_pin <= brk_q ? 1'b0 : sh_q[1];
                            sh_q     <= {1'b0, sh_q[7:1]};
                        end
                        bit_q <= bit_q + 4'h1;
                    end
                end
                lbsp_pkg::TX_STOP: begin
                    mck_q <= 1'b0;
                    if (step || txc_q[lbsp_pkg::TXC_SYNC]) begin
                        tx_q  <= lbsp_pkg::TX_IDLE;
                        brk_q <= 1'b0;
                    end
                end
                default: tx_q <= lbsp_pkg::TX_IDLE;
            endcase
        end
    end

    assign O_RECEIVE_DATA_PIN    = tx_q_pin;
    assign O_RECEIVE_DATA_PIN_OE = en_port && txc_q[lbsp_pkg::TXC_SYNC] && tx_q != lbsp_pkg::TX_IDLE;
    assign O_TX_CK    = txc_q[lbsp_pkg::TXC_SYNC] ? (mck_q ^ ckp) : tx_q_pin;
    assign O_TX_CK_OE = en_port && (sync_m || !txc_q[lbsp_pkg::TXC_SYNC]);

    // ------------------------------------------------------------
    // receiver with auto-wake
    // ------------------------------------------------------------
    logic [15:0] rcnt_q;
    logic [3:0]  rbit_q;
    logic [7:0]  rsh_q;
    logic [1:0]  wedge_q;
    assign rx_done = (rx_q == lbsp_pkg::RX_STOP) && (rcnt_q == div_q);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RESETN) begin
            rx_q    <= lbsp_pkg::RX_IDLE;
            rcnt_q  <= 16'h0000;
            rbit_q  <= 4'h0;
            rsh_q   <= 8'h00;
            rxd_q   <= 8'h00;
            wedge_q <= 2'h0;
        end else begin
            case (rx_q)
                lbsp_pkg::RX_IDLE: begin
                    rcnt_q <= 16'h0000;
                    rbit_q <= 4'h0;
                    wedge_q <= 2'h0;
                    if (en_port && bdc_q[lbsp_pkg::BDC_WAKE]) begin
                        rx_q <= lbsp_pkg::RX_WAKE;
                    end else if (en_port && rxc_q[lbsp_pkg::RXC_CREN] && !rx_s_q) begin
                        rx_q <= lbsp_pkg::RX_DATA;
                    end
                end
                lbsp_pkg::RX_WAKE: begin
                    // RL12: count two line edges
                    if (rx_edge) wedge_q <= wedge_q + 2'h1;
                    if (rx_edge && wedge_q == lbsp_pkg::WAKE_EDGES - 2'h1) begin
                        rx_q <= lbsp_pkg::RX_IDLE;
                    end
                end
                lbsp_pkg::RX_DATA: begin
                    // sample mid bit after a half-period start offset
                    rcnt_q <= (rcnt_q == div_q) ? 16'h0000 : rcnt_q + 16'h0001;
                    if (rcnt_q == {1'b0, div_q[15:1]}) begin
                        if (rbit_q != 4'h0) rsh_q <= {rx_s_q, rsh_q[7:1]};
                        rbit_q <= rbit_q + 4'h1;
                        if (rbit_q == lbsp_pkg::DATA_BITS) rx_q <= lbsp_pkg::RX_STOP;
                    end
                end
                lbsp_pkg::RX_STOP: begin
                    rcnt_q <= rcnt_q + 16'h0001;
                    if (rx_done) begin
                        rxd_q <= rsh_q;
                        rx_q  <= lbsp_pkg::RX_IDLE;
                    end
                end
                default: rx_q <= lbsp_pkg::RX_IDLE;
            endcase
        end
    end

    // RL10: buffer-empty event on hand-off to shifter
    assign ev[lbsp_pkg::EV_TXBE]    = hold_take;
    assign ev[lbsp_pkg::EV_RXRDY]   = rx_done ||
        (rx_q == lbsp_pkg::RX_WAKE && rx_edge && wedge_q == lbsp_pkg::WAKE_EDGES - 2'h1);
    assign ev[lbsp_pkg::EV_BRKDONE] = send_break_request_clr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence brk_load_s;
        hold_take && txc_q[lbsp_pkg::TXC_SEND_BREAK_REQUEST] && !txc_q[lbsp_pkg::TXC_SYNC];
    endsequence

    brk_zero_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL5
        brk_load_s |=> (sh_q == 8'h00 && brk_q))
        else $error("break did not load zeros");
    brk_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL6
        send_break_request_clr |=> !txc_q[lbsp_pkg::TXC_SEND_BREAK_REQUEST])
        else $error("send-break not cleared");
    brk_line_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL3
        (brk_q && tx_q == lbsp_pkg::TX_DATA) |-> !tx_q_pin)
        else $error("break line not low");
    brk_len_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL3
        (brk_q && tx_q == lbsp_pkg::TX_STOP) |-> bit_q == lbsp_pkg::BREAK_BITS)
        else $error("break length wrong");
    shift_register_empty_flag_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL8
        (tx_q != lbsp_pkg::TX_IDLE) |=> !txc_q[lbsp_pkg::TXC_SHIFT_REGISTER_EMPTY_FLAG])
        else $error("empty flag set while shifting");
    hold_pre_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL7
        (brk_q && hit(bus, lbsp_pkg::REG_TX_HOLD)) |=> hold_full_q)
        else $error("preload refused in break");
    txbe_evt_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL10
        hold_take |=> stat_q[lbsp_pkg::EV_TXBE] && !hold_full_q)
        else $error("buffer-empty not flagged");
    load_cond_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL4
        hold_take |-> txc_q[lbsp_pkg::TXC_TRANSMIT_ENABLE_BIT])
        else $error("load without enable");
    wake_irq_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) // RL12
        ($past(rx_q) == lbsp_pkg::RX_WAKE && $fell(bdc_q[lbsp_pkg::BDC_WAKE])) |->
        stat_q[lbsp_pkg::EV_RXRDY])
        else $error("wake without receive event");
endmodule // lbsp_top
